//--- pec_map.vh
// Register offsets, field positions and reset values of the performance event counters
`ifndef PEC_MAP_VH
`define PEC_MAP_VH

// -----------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------
`define PEC_ADDR_W            12
`define PEC_OFF_CONTROL       12'hf00
`define PEC_OFF_COUNTER_0     12'hf40
`define PEC_OFF_COUNTER_1     12'hf80
`define PEC_OFF_MISS_ADDR     12'hfc0

// -----------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------
`define PEC_NODE_MASK_HI      31
`define PEC_NODE_MASK_LO      24
`define PEC_C1_HALT_BIT       23
`define PEC_C1_RUN_BIT        22
`define PEC_C1_SEL_HI         20
`define PEC_C1_SEL_LO         16
`define PEC_C0_HALT_BIT       15
`define PEC_C0_RUN_BIT        14
`define PEC_C0_SEL_HI         12
`define PEC_C0_SEL_LO         8
`define PEC_RATE_HI           3
`define PEC_RATE_LO           2
`define PEC_C1_OVFL_BIT       1
`define PEC_C0_OVFL_BIT       0

// -----------------------------------------------------------------
// Event codes and widths
// -----------------------------------------------------------------
`define PEC_EV_W              5
`define PEC_NUM_EV            20
`define PEC_EV_MISS_READ      5'h00
`define PEC_EV_MISS_WRITE     5'h01
`define PEC_EV_MISS_SHARED    5'h02
`define PEC_EV_BUS_READ       5'h0f
`define PEC_EV_BUS_WRITE      5'h10
`define PEC_EV_VICTIM_WRITE   5'h11
`define PEC_EV_CARRY0         5'h14
`define PEC_MISS_ADDR_W       29
`define PEC_SAMPLE_CNT_W      8
`define PEC_RST_WORD          32'h0000_0000
`define PEC_RST_SEL           5'h00
`define PEC_RST_MASK          8'h00
`define PEC_RST_RATE          2'h0

`endif

//--- pec_miss_sampler.v
// Sampler that captures the address of every nth backup-cache miss
`timescale 1ns/1ps

module pec_miss_sampler (
   core_clk,
   rst_n,
   miss_pulse,
   miss_addr,
   sample_rate,
   sampled_addr
);
`include "pec_map.vh"
   input  wire                           core_clk;
   input  wire                           rst_n;
   input  wire                           miss_pulse;
   input  wire [`PEC_MISS_ADDR_W-1:0]    miss_addr;
   input  wire [1:0]                     sample_rate;
   output reg  [`PEC_MISS_ADDR_W-1:0]    sampled_addr;

   reg  [`PEC_SAMPLE_CNT_W-1:0] miss_cnt_reg;
   reg  [`PEC_SAMPLE_CNT_W-1:0] terminal;

   // -----------------------------------------------------------------
   // Rate decode
   // -----------------------------------------------------------------
   always @* begin
      case (sample_rate)                                     // see R3
         2'h0:    terminal = 8'h1f;
         2'h1:    terminal = 8'h3f;
         2'h2:    terminal = 8'h7f;
         2'h3:    terminal = 8'hff;
         default: terminal = 8'hff;
      endcase
   end

   // -----------------------------------------------------------------
   // Miss count and capture
   // -----------------------------------------------------------------
   // Counting against the live terminal value: a rate change takes
   // effect at once, possibly making the current interval longer.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         miss_cnt_reg <= 8'h00;
         sampled_addr <= 29'h0000_0000;
      end else if (miss_pulse) begin                         // see R14
         if (miss_cnt_reg >= terminal) begin
            miss_cnt_reg <= 8'h00;
            sampled_addr <= miss_addr;
         end else begin
            miss_cnt_reg <= miss_cnt_reg + 8'h01;
         end
      end
   end

endmodule // pec_miss_sampler

//--- pec_event_counters.v
// Two 32-bit performance event counters with cascade and miss-address sampling
// Operation
// R1 - Control bits 12:8 choose the event counted by counter 0.
// R2 - Software writes zero to reserved control bits 7:4.
// R3 - Rate code 00..11 samples every 32nd, 64th, 128th, 256th miss.
// R4 - Control bit 1 flags counter 1 overflow, bit 0 counter 0 overflow.
// R5 - Resetting a counter clears its overflow flag.
// R6 - Each counter is 32 bits with its own overflow flag.
// R7 - The two counters may be chained into one 64-bit count.
// R8 - Each counter starts and stops on its own control bits.
// R9 - Counter value reads back whether stopped or running.
// R10 - A stopped counter keeps its value and resumes from it.
// R11 - Writing a counter zeroes it, clears overflow, and stops it.
// R12 - Write data to a counter register is never loaded.
// R13 - Count only selected events while the counter is enabled.
// R14 - Read, write and shared-block misses feed miss-address sampling.
// R15 - Miss-address bits 31:29 read zero; bits 28:0 hold the address.
// R16 - Events are qualified by counter select and node mask.
// R17 - Writing one to bit 22 runs counter 1; bit 23 halts it.
// R18 - Counter 1 event code 10100 counts counter 0 carry out.
// R19 - Bus reads, writes, victim writes count only for masked-in nodes.
// R20 - On wrap to zero, set overflow and keep counting.
`timescale 1ns/1ps

module pec_event_counters (
   core_clk,
   rst_n,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   ev_pulse,
   ev_node,
   miss_addr,
   counter0_running,
   counter1_running
);
`include "pec_map.vh"
   input  wire                           core_clk;
   input  wire                           rst_n;
   input  wire [`PEC_ADDR_W-1:0]         reg_addr;
   input  wire [31:0]                    reg_wdata;
   input  wire                           reg_wr;
   input  wire                           reg_rd;
   output reg  [31:0]                    reg_rdata;
   input  wire [`PEC_NUM_EV-1:0]         ev_pulse;
   input  wire [7:0]                     ev_node;
   input  wire [`PEC_MISS_ADDR_W-1:0]    miss_addr;
   output reg                            counter0_running;
   output reg                            counter1_running;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   reg  [7:0]                   node_mask_reg;
   reg  [`PEC_EV_W-1:0]         counter0_event_select_reg;
   reg  [`PEC_EV_W-1:0]         counter1_event_select_reg;
   reg  [1:0]                   miss_sample_rate_reg;
   reg                          counter0_overflow_reg;
   reg                          counter1_overflow_reg;
   reg  [31:0]                  count_value_0_reg;
   reg  [31:0]                  count_value_1_reg;
   reg  [31:0]                  count_value_0_next;
   reg  [31:0]                  count_value_1_next;
   reg                          carry0;
   reg                          inc0;
   reg                          inc1;
   reg  [`PEC_NUM_EV-1:0]       ev_qual;
   wire [`PEC_MISS_ADDR_W-1:0]  sampled_addr;
   wire                         miss_pulse;

   wire wr_ctl = reg_wr && (reg_addr == `PEC_OFF_CONTROL);
   wire wr_c0  = reg_wr && (reg_addr == `PEC_OFF_COUNTER_0);
   wire wr_c1  = reg_wr && (reg_addr == `PEC_OFF_COUNTER_1);

   // -----------------------------------------------------------------
   // Event selection
   // -----------------------------------------------------------------
   // Picks one qualified event line; codes with no source count nothing
   function pick_event;
      input [`PEC_NUM_EV-1:0] lines;
      input [`PEC_EV_W-1:0]   code;
      begin
         if (code < `PEC_NUM_EV)
            pick_event = lines[code];
         else
            pick_event = 1'b0;
      end
   endfunction

   // Node-masked bus events only count for enabled nodes
   always @* begin
      ev_qual = ev_pulse;
      if ((ev_node & node_mask_reg) == 8'h00) begin          // see R19
         ev_qual[`PEC_EV_BUS_READ]    = 1'b0;
         ev_qual[`PEC_EV_BUS_WRITE]   = 1'b0;
         ev_qual[`PEC_EV_VICTIM_WRITE] = 1'b0;
      end
   end

   assign miss_pulse = ev_pulse[`PEC_EV_MISS_READ] |
                       ev_pulse[`PEC_EV_MISS_WRITE] |
                       ev_pulse[`PEC_EV_MISS_SHARED];          // see R14

   // -----------------------------------------------------------------
   // Counter arithmetic
   // -----------------------------------------------------------------
   always @* begin
      inc0 = counter0_running &&
             pick_event(ev_qual, counter0_event_select_reg);     // see R1, R13, R16
      {carry0, count_value_0_next} = {1'b0, count_value_0_reg} +
                                     {32'h0000_0000, inc0};      // see R6, R20
      if (counter1_event_select_reg == `PEC_EV_CARRY0)
         inc1 = counter1_running && carry0;                      // see R7, R18
      else
         inc1 = counter1_running &&
                pick_event(ev_qual, counter1_event_select_reg);  // see R13, R16
      count_value_1_next = count_value_1_reg + {31'h0000_0000, inc1};
   end

   // -----------------------------------------------------------------
   // Control register
   // -----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         node_mask_reg             <= `PEC_RST_MASK;
         counter0_event_select_reg <= `PEC_RST_SEL;
         counter1_event_select_reg <= `PEC_RST_SEL;
         miss_sample_rate_reg      <= `PEC_RST_RATE;
      end else if (wr_ctl) begin
         node_mask_reg             <= reg_wdata[`PEC_NODE_MASK_HI:`PEC_NODE_MASK_LO];
         counter1_event_select_reg <= reg_wdata[`PEC_C1_SEL_HI:`PEC_C1_SEL_LO];
         counter0_event_select_reg <= reg_wdata[`PEC_C0_SEL_HI:`PEC_C0_SEL_LO];
         miss_sample_rate_reg      <= reg_wdata[`PEC_RATE_HI:`PEC_RATE_LO];
      end
   end

   // -----------------------------------------------------------------
   // Counter 0
   // -----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_value_0_reg     <= `PEC_RST_WORD;
         counter0_overflow_reg <= 1'b0;
         counter0_running      <= 1'b0;
      end else if (wr_c0) begin
         // Data is dropped; the write only resets and stops
         count_value_0_reg     <= `PEC_RST_WORD;             // see R11, R12
         counter0_overflow_reg <= 1'b0;                      // see R5
         counter0_running      <= 1'b0;
      end else begin
         count_value_0_reg <= count_value_0_next;            // see R10
         if (carry0)
            counter0_overflow_reg <= 1'b1;                   // see R20
         if (wr_ctl && reg_wdata[`PEC_C0_HALT_BIT])
            counter0_running <= 1'b0;                        // see R8
         else if (wr_ctl && reg_wdata[`PEC_C0_RUN_BIT])
            counter0_running <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Counter 1
   // -----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_value_1_reg     <= `PEC_RST_WORD;
         counter1_overflow_reg <= 1'b0;
         counter1_running      <= 1'b0;
      end else if (wr_c1) begin
         count_value_1_reg     <= `PEC_RST_WORD;             // see R11, R12
         counter1_overflow_reg <= 1'b0;                      // see R5
         counter1_running      <= 1'b0;
      end else begin
         count_value_1_reg <= count_value_1_next;            // see R10
         if (inc1 && (count_value_1_reg == 32'hffff_ffff))
            counter1_overflow_reg <= 1'b1;                   // see R20
         // Halt wins if both bits are written at once
         if (wr_ctl && reg_wdata[`PEC_C1_HALT_BIT])
            counter1_running <= 1'b0;                        // see R17
         else if (wr_ctl && reg_wdata[`PEC_C1_RUN_BIT])
            counter1_running <= 1'b1;                        // see R17
      end
   end

   // -----------------------------------------------------------------
   // Miss-address sampler
   // -----------------------------------------------------------------
   pec_miss_sampler u_sampler (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .miss_pulse   (miss_pulse),
      .miss_addr    (miss_addr),
      .sample_rate  (miss_sample_rate_reg),
      .sampled_addr (sampled_addr)
   );

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   // Run and halt bits are write-only and read zero
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `PEC_OFF_CONTROL:
               reg_rdata <= {node_mask_reg, 3'h0, counter1_event_select_reg,
                             3'h0, counter0_event_select_reg, 4'h0,
                             miss_sample_rate_reg, counter1_overflow_reg,
                             counter0_overflow_reg};        // see R4
            `PEC_OFF_COUNTER_0: reg_rdata <= count_value_0_reg; // see R9
            `PEC_OFF_COUNTER_1: reg_rdata <= count_value_1_reg; // see R9
            `PEC_OFF_MISS_ADDR: reg_rdata <= {3'h0, sampled_addr}; // see R15
            default:            reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule // pec_event_counters

//--- pec_event_counters_chk.sv
// Port-level assertions for the performance event counters
`timescale 1ns/1ps
`include "pec_map.vh"
module pec_chk (
   input wire                        core_clk,
   input wire                        rst_n,
   input wire [`PEC_ADDR_W-1:0]      reg_addr,
   input wire [31:0]                 reg_wdata,
   input wire                        reg_wr,
   input wire                        reg_rd,
   input wire [31:0]                 reg_rdata,
   input wire [`PEC_NUM_EV-1:0]      ev_pulse,
   input wire [7:0]                  ev_node,
   input wire [`PEC_MISS_ADDR_W-1:0] miss_addr,
   input wire                        counter0_running,
   input wire                        counter1_running
);
   // ---------------------------------
   // Run state and read port checks
   // ---------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire wr_ctl = reg_wr && reg_addr == `PEC_OFF_CONTROL;
   wire wr_c0  = reg_wr && reg_addr == `PEC_OFF_COUNTER_0;
   wire wr_c1  = reg_wr && reg_addr == `PEC_OFF_COUNTER_1;
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   c0_wr_stop_a: assert property (wr_c0 |=> !counter0_running)
      else $error("counter 0 still running after write");
   c1_wr_stop_a: assert property (wr_c1 |=> !counter1_running)
      else $error("counter 1 still running after write");
   c1_run_a: assert property (wr_ctl && reg_wdata[22] && !reg_wdata[23] |=> counter1_running)
      else $error("counter 1 did not start");
   c1_halt_a: assert property (wr_ctl && reg_wdata[23] |=> !counter1_running)
      else $error("counter 1 did not stop");
   c0_run_a: assert property (wr_ctl && reg_wdata[14] && !reg_wdata[15] |=> counter0_running)
      else $error("counter 0 did not start");
   run_hold_a: assert property (!reg_wr |=> $stable({counter0_running, counter1_running}))
      else $error("run state changed without a write");
   c0_indep_a: assert property (wr_c0 |=> $stable(counter1_running))
      else $error("counter 1 disturbed by counter 0 write");
   miss_top_a: assert property (reg_rd && reg_addr == `PEC_OFF_MISS_ADDR |=>
      reg_rdata[31:29] == 3'h0)
      else $error("miss address top bits not zero");
endmodule // pec_chk

bind pec_event_counters pec_chk u_pec_chk (.core_clk(core_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ev_pulse(ev_pulse), .ev_node(ev_node), .miss_addr(miss_addr),
   .counter0_running(counter0_running), .counter1_running(counter1_running));

//--- pec_ev_source.sv
// Model of the cache and bus logic that raises event pulses
`timescale 1ns/1ps
module pec_ev_source (
   input wire        core_clk,
   input wire        fire,
   input wire [4:0]  code,
   input wire [7:0]  node,
   input wire [28:0] addr,
   output reg [19:0] ev_pulse,
   output reg [7:0]  ev_node,
   output reg [28:0] miss_addr
);
   // ---------------------------------
   // One-cycle event pulses
   // ---------------------------------
   initial begin
      ev_pulse = 20'h0;
      ev_node = 8'h0;
      miss_addr = 29'h0;
   end
   // Idle node and address toggle so stale values never look valid
   always @(posedge core_clk) begin
      ev_pulse <= fire ? (20'h1 << code) : 20'h0;
      ev_node <= fire ? node : ~ev_node;
      miss_addr <= fire ? addr : ~miss_addr;
   end
endmodule // pec_ev_source

//--- tb_top.sv
// Self-checking testbench for the performance event counters
`timescale 1ns/1ps
`include "pec_map.vh"
module tb_top;
   reg         core_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [11:0] reg_addr = 12'h0;
   reg  [31:0] reg_wdata = 32'h0;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   reg         fire = 1'b0;
   reg  [4:0]  code = 5'h0;
   reg  [7:0]  node = 8'h0;
   reg  [28:0] addr = 29'h0;
   wire [31:0] reg_rdata;
   wire [19:0] ev_pulse;
   wire [7:0]  ev_node;
   wire [28:0] miss_addr;
   wire        counter0_running;
   wire        counter1_running;
   reg  [31:0] rv;
   reg  [28:0] last;
   integer     n_fail = 0;
   integer     n_tests = 0;
   integer     r;
   integer     i;
   always #20 core_clk = ~core_clk;
   pec_event_counters u_pec_event_counters (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ev_pulse(ev_pulse), .ev_node(ev_node), .miss_addr(miss_addr),
      .counter0_running(counter0_running), .counter1_running(counter1_running));
   pec_ev_source u_pec_ev_source (.core_clk(core_clk), .fire(fire), .code(code),
      .node(node), .addr(addr), .ev_pulse(ev_pulse), .ev_node(ev_node),
      .miss_addr(miss_addr));
   // ---------------------------------
   // Bus and compare tasks
   // ---------------------------------
   task chk(input [95:0] what, input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // Every control word written below keeps reserved bits 7:4 at zero
   task wr(input [11:0] a, input [31:0] d);
      begin
         @(posedge core_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge core_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rchk(input [95:0] what, input [11:0] a, input [31:0] exp);
      begin
         @(posedge core_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         #1 rv = reg_rdata;
         chk(what, rv, exp);
      end
   endtask
   task ev(input [4:0] c, input [7:0] n, input [28:0] a);
      begin
         @(posedge core_clk);
         fire <= 1'b1;
         code <= c;
         node <= n;
         addr <= a;
         @(posedge core_clk);
         fire <= 1'b0;
      end
   endtask
   task tally_and_finish;
      begin
         if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task t_reset;
      begin
         rchk("control", `PEC_OFF_CONTROL, 32'h0);
         rchk("count0", `PEC_OFF_COUNTER_0, 32'h0);
         rchk("count1", `PEC_OFF_COUNTER_1, 32'h0);
         rchk("missaddr", `PEC_OFF_MISS_ADDR, 32'h0);
         rchk("unmapped", 12'h010, 32'h0);
      end
   endtask
   // Each rate is checked one miss short of the capture and at it
   task t_sampler;
      begin
         last = 29'h0;
         for (r = 0; r < 4; r = r + 1) begin
            wr(`PEC_OFF_CONTROL, r << 2);
            for (i = 0; i < (32 << r); i = i + 1) begin
               if (i == (32 << r) - 1)
                  rchk("missaddr", `PEC_OFF_MISS_ADDR, {3'h0, last});
               ev(i % 3, 8'h0, 29'h1abc_0000 + (r << 12) + i);
            end
            last = 29'h1abc_0000 + (r << 12) + (32 << r) - 1;
            rchk("missaddr", `PEC_OFF_MISS_ADDR, {3'h0, last});
         end
      end
   endtask
   task t_count;
      begin
         wr(`PEC_OFF_CONTROL, 32'h0000_4300);
         for (i = 0; i < 3; i = i + 1)
            ev(5'h03, 8'h0, 29'h0);
         ev(5'h04, 8'h0, 29'h0);
         rchk("count0", `PEC_OFF_COUNTER_0, 32'h3);
         chk("run0", counter0_running, 32'h1);
         wr(`PEC_OFF_CONTROL, 32'h0000_8300);
         ev(5'h03, 8'h0, 29'h0);
         ev(5'h03, 8'h0, 29'h0);
         rchk("count0", `PEC_OFF_COUNTER_0, 32'h3);
         chk("run0", counter0_running, 32'h0);
         wr(`PEC_OFF_CONTROL, 32'h0000_4300);
         ev(5'h03, 8'h0, 29'h0);
         rchk("count0", `PEC_OFF_COUNTER_0, 32'h4);
         rchk("count1", `PEC_OFF_COUNTER_1, 32'h0);
         wr(`PEC_OFF_COUNTER_0, 32'hffff_ffff);
         rchk("count0", `PEC_OFF_COUNTER_0, 32'h0);
         chk("run0", counter0_running, 32'h0);
      end
   endtask
   // Node 1 is outside the mask; node pair 1 and 2 overlaps it
   task t_mask;
      begin
         wr(`PEC_OFF_CONTROL, 32'h044f_0000);
         rchk("control", `PEC_OFF_CONTROL, 32'h040f_0000);
         ev(5'h0f, 8'h04, 29'h0);
         ev(5'h0f, 8'h02, 29'h0);
         ev(5'h0f, 8'h06, 29'h0);
         ev(5'h10, 8'h04, 29'h0);
         rchk("count1", `PEC_OFF_COUNTER_1, 32'h2);
         wr(`PEC_OFF_CONTROL, 32'h0014_0000);
         ev(5'h00, 8'h04, 29'h0);
         rchk("count1", `PEC_OFF_COUNTER_1, 32'h2);
         wr(`PEC_OFF_COUNTER_1, 32'h1234_5678);
         rchk("count1", `PEC_OFF_COUNTER_1, 32'h0);
      end
   endtask
   initial begin
      repeat (40000) @(posedge core_clk);
      n_fail = n_fail + 1;
      tally_and_finish;
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset;
      t_sampler;
      t_count;
      t_mask;
      tally_and_finish;
   end
endmodule // tb_top
